// >>> logic/hit_merge_params.svh
// Constants for the eight-channel hit merge arbiter
`ifndef HIT_MERGE_PARAMS_SVH
`define HIT_MERGE_PARAMS_SVH

// ==========================================================
// Geometry
`define NUM_CHANNELS      8
`define CHAN_IDX_W        3
`define QUEUE_DEPTH       4
`define QUEUE_PTR_W       2
`define QUEUE_CNT_W       3
`define PAIR_DEPTH        2
`define TIME_W            16
`define WIDTH_W           8

// ==========================================================
// Timing
`define CLK_PERIOD_PS     20000
`define DEAD_TIME_PS      10000
`define DEAD_CYCLES       ((`DEAD_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SERVICE_INTERVAL  4
`define DEAD_CODE_SHORT   2'h1

`endif

// >>> logic/hit_merge_pkg.sv
// Types shared by the hit merge arbiter and its channel queues
package hit_merge_pkg;

  // ==========================================================
  // Measurement word carried to the level-1 buffer
  typedef struct packed {
    logic [2:0]  channel;
    logic        paired;
    logic        trailing;
    logic [15:0] stamp;
    logic [7:0]  width;
  } meas_type;

  // ==========================================================
  // Hit capture per channel
  typedef struct packed {
    logic        lead;
    logic        trail;
  } edge_type;

  // ==========================================================
  // Configuration bundle
  typedef struct packed {
    logic        enable_pair;
    logic [1:0]  dead_code;
  } cfg_type;

  // ==========================================================
  // Arbiter states, Gray along idle -> load -> serve
  typedef enum logic [1:0] {
    ARB_IDLE  = 2'b00,
    ARB_LOAD  = 2'b01,
    ARB_SERVE = 2'b11
  } arb_state_type;

endpackage : hit_merge_pkg

// >>> logic/hit_channel_queue.sv
// One hit channel: dead time, edge pairing and four-entry derandomizer
`timescale 1ns/1ps
`default_nettype none
`include "hit_merge_params.svh"

module hit_channel_queue (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  // Configuration and time base
  input  wire hit_merge_pkg::cfg_type   cfg,
  input  wire logic [`TIME_W-1:0]       coarse_time,
  input  wire logic [`CHAN_IDX_W-1:0]   chan_id,
  // Front-end edges
  input  wire hit_merge_pkg::edge_type  hit,
  // Arbiter side
  output logic                          req,
  input  wire logic                     pop,
  output hit_merge_pkg::meas_type       head
);
  import hit_merge_pkg::*;

  // ==========================================================
  // Dead time
  logic [1:0]              dead_cnt_ff;
  logic [1:0]              nxt_dead_cnt;
  wire                     dead_on    = (cfg.dead_code == `DEAD_CODE_SHORT);
  wire                     blind      = (dead_cnt_ff != 2'h0);
  wire                     lead_in    = hit.lead & ~blind;
  wire                     trail_in   = hit.trail;
  assign nxt_dead_cnt = (lead_in && dead_on) ? 2'(`DEAD_CYCLES) :
                        (blind ? dead_cnt_ff - 2'h1 : 2'h0);

  // ==========================================================
  // Pairing: hold leading stamp until trailing edge
  logic                    lead_held_ff;
  logic [`TIME_W-1:0]      lead_stamp_ff;
  wire [`TIME_W-1:0]       pulse_len  = coarse_time - lead_stamp_ff;
  wire [`WIDTH_W-1:0]      width_sat  = (pulse_len > `TIME_W'(8'hff)) ? 8'hff : pulse_len[`WIDTH_W-1:0];

  // ==========================================================
  // Derandomizer
  meas_type                mem [`QUEUE_DEPTH];
  logic [`QUEUE_PTR_W-1:0] wr_ptr_ff;
  logic [`QUEUE_PTR_W-1:0] rd_ptr_ff;
  logic [`QUEUE_CNT_W-1:0] cnt_ff;
  meas_type                new_meas;
  logic                    want_push;

  // Paired words take two slots each, so capacity halves
  wire [`QUEUE_CNT_W-1:0]  limit = cfg.enable_pair ? `QUEUE_CNT_W'(2 * `PAIR_DEPTH)
                                                   : `QUEUE_CNT_W'(`QUEUE_DEPTH);
  wire [`QUEUE_CNT_W-1:0]  cost  = cfg.enable_pair ? `QUEUE_CNT_W'(2) : `QUEUE_CNT_W'(1);
  wire                     fits  = (cnt_ff + cost) <= limit;
  wire                     push  = want_push & fits;
  wire [`QUEUE_CNT_W-1:0]  freed = pop ? (head.paired ? `QUEUE_CNT_W'(2) : `QUEUE_CNT_W'(1)) : '0;

  always_comb begin
    new_meas          = '0;
    new_meas.channel  = chan_id;
    new_meas.stamp    = coarse_time;
    want_push         = 1'b0;
    if (cfg.enable_pair) begin
      want_push        = trail_in & lead_held_ff;
      new_meas.paired  = 1'b1;
      new_meas.stamp   = lead_stamp_ff;
      new_meas.width   = width_sat;
    end else if (lead_in) begin
      want_push        = 1'b1;
    end else if (trail_in) begin
      want_push         = 1'b1;
      new_meas.trailing = 1'b1;
    end
  end

  assign req  = (cnt_ff != '0);
  assign head = mem[rd_ptr_ff];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dead_cnt_ff   <= 2'h0;
      lead_held_ff  <= 1'b0;
      lead_stamp_ff <= '0;
      wr_ptr_ff     <= '0;
      rd_ptr_ff     <= '0;
      cnt_ff        <= '0;
    end else begin
      dead_cnt_ff <= nxt_dead_cnt;
      if (cfg.enable_pair && lead_in) begin
        lead_held_ff  <= 1'b1;
        lead_stamp_ff <= coarse_time;
      end else if (trail_in) begin
        lead_held_ff  <= 1'b0;
      end
      if (push) begin
        mem[wr_ptr_ff] <= new_meas;
        wr_ptr_ff      <= wr_ptr_ff + `QUEUE_PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + `QUEUE_PTR_W'(1);
      end
      cnt_ff <= cnt_ff + (push ? cost : '0) - freed;
    end
  end

endmodule : hit_channel_queue
`default_nettype wire

// >>> logic/channel_hit_merge_arbiter.sv
// Eight-channel hit merge arbiter feeding one level-1 buffer write port
`timescale 1ns/1ps
`default_nettype none
`include "hit_merge_params.svh"

module channel_hit_merge_arbiter (
  // Clock and reset
  input  wire logic                                    sys_clk,
  input  wire logic                                    rstn,
  // Configuration
  input  wire hit_merge_pkg::cfg_type                  cfg,
  // Front-end hit edges, one per channel
  input  wire hit_merge_pkg::edge_type [`NUM_CHANNELS-1:0] hit,
  // Level-1 buffer write port
  output logic                                         l1_wr_en,
  output hit_merge_pkg::meas_type                      l1_wr_data,
  // Status
  output logic [`NUM_CHANNELS-1:0]                     pending
);
  import hit_merge_pkg::*;

  // ==========================================================
  // Time base
  logic [`TIME_W-1:0]            coarse_ff;

  // ==========================================================
  // Channel queues
  logic [`NUM_CHANNELS-1:0]      chan_req;
  logic [`NUM_CHANNELS-1:0]      chan_pop;
  meas_type                      chan_head [`NUM_CHANNELS];

  genvar g;
  generate
    for (g = 0; g < `NUM_CHANNELS; g++) begin : gen_chan
      hit_channel_queue u_queue (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .cfg         (cfg),
        .coarse_time (coarse_ff),
        .chan_id     (`CHAN_IDX_W'(g)),
        .hit         (hit[g]),
        .req         (chan_req[g]),
        .pop         (chan_pop[g]),
        .head        (chan_head[g])
      );
    end
  endgenerate

  // ==========================================================
  // Synchronisation delay: the arbiter sees requests one clock late,
  // which is why tail channels can miss the reload moment
  logic [`NUM_CHANNELS-1:0]      req_seen_ff;
  logic [`NUM_CHANNELS-1:0]      pop_last_ff;

  // ==========================================================
  // Per-channel service pacing
  logic [1:0]                    pace_ff [`NUM_CHANNELS];
  logic [`NUM_CHANNELS-1:0]      pace_ok;

  generate
    for (g = 0; g < `NUM_CHANNELS; g++) begin : gen_pace
      assign pace_ok[g] = (pace_ff[g] == 2'h0);
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          pace_ff[g] <= 2'h0;
        end else if (chan_pop[g]) begin
          pace_ff[g] <= 2'(`SERVICE_INTERVAL - 1);
        end else if (pace_ff[g] != 2'h0) begin
          pace_ff[g] <= pace_ff[g] - 2'h1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Request queue and fixed-priority pick
  arb_state_type                 state_ff;
  arb_state_type                 nxt_state;
  logic [`NUM_CHANNELS-1:0]      rq_ff;
  logic [`NUM_CHANNELS-1:0]      nxt_rq;

  // A just-popped channel's request is stale for one clock, so the
  // reload must not count on it
  wire  [`NUM_CHANNELS-1:0]      live_req = req_seen_ff & ~pop_last_ff;
  // Head of the round waits out its pacing instead of being skipped,
  // so grants within one round never step back to a lower channel
  wire  [`NUM_CHANNELS-1:0]      eligible   = rq_ff & chan_req;
  wire  [`NUM_CHANNELS-1:0]      round_head = eligible & (~eligible + `NUM_CHANNELS'(1));
  wire  [`NUM_CHANNELS-1:0]      pick       = round_head & pace_ok;
  wire                           any_pick = (pick != '0);
  wire                           rq_empty = (rq_ff == '0);

  logic [`CHAN_IDX_W-1:0]        pick_idx;
  always_comb begin
    pick_idx = '0;
    for (int i = `NUM_CHANNELS - 1; i >= 0; i--) begin
      if (pick[i]) begin
        pick_idx = `CHAN_IDX_W'(i);
      end
    end
  end

  // One grant per clock, one entry per grant
  assign chan_pop = (state_ff == ARB_SERVE) ? pick : '0;

  always_comb begin
    nxt_state = state_ff;
    nxt_rq    = rq_ff;
    case (state_ff)
      ARB_IDLE: begin
        nxt_state = ARB_LOAD;
      end
      ARB_LOAD: begin
        nxt_rq = live_req;
        if (live_req != '0) begin
          nxt_state = ARB_SERVE;
        end
      end
      ARB_SERVE: begin
        nxt_rq = rq_ff & ~pick;
        if (rq_empty || ((rq_ff & ~pick) == '0)) begin
          nxt_state = ARB_LOAD;
        end
      end
      default: begin
        nxt_state = ARB_IDLE;
        nxt_rq    = '0;
      end
    endcase
  end

  // Drop queue bits whose channel went empty, so a round never stalls
  wire  [`NUM_CHANNELS-1:0]      rq_trim = nxt_rq & (chan_req | (state_ff == ARB_LOAD ? '1 : '0));

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= ARB_IDLE;
      rq_ff       <= '0;
      req_seen_ff <= '0;
      pop_last_ff <= '0;
      coarse_ff   <= '0;
    end else begin
      state_ff    <= nxt_state;
      rq_ff       <= rq_trim;
      req_seen_ff <= chan_req;
      pop_last_ff <= chan_pop;
      coarse_ff   <= coarse_ff + `TIME_W'(1);
    end
  end

  // ==========================================================
  // Shared write path
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      l1_wr_en   <= 1'b0;
      l1_wr_data <= '0;
      pending    <= '0;
    end else begin
      l1_wr_en   <= (state_ff == ARB_SERVE) && any_pick;
      l1_wr_data <= chan_head[pick_idx];
      pending    <= chan_req;
    end
  end

endmodule : channel_hit_merge_arbiter
`default_nettype wire

// >>> tb/hit_merge_monitor.sv
// Port assertions for the hit merge arbiter
`timescale 1ns/1ps
`default_nettype none
`include "hit_merge_params.svh"

module hit_merge_monitor (
  // Clock and reset
  input wire logic                      sys_clk,
  input wire logic                      rstn,
  // Configuration and hits
  input wire hit_merge_pkg::cfg_type    cfg,
  input wire hit_merge_pkg::edge_type [`NUM_CHANNELS-1:0] hit,
  // Write port and status
  input wire logic                      l1_wr_en,
  input wire hit_merge_pkg::meas_type   l1_wr_data,
  input wire logic [`NUM_CHANNELS-1:0]  pending
);
  import hit_merge_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [2:0]  ch;
  logic [15:0] cyc_ff;
  logic [15:0] last_ff [8];
  assign ch = l1_wr_data.channel;
  // Stamp wrap is ignored: runs stay far below 65536 clocks
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_ff  <= 16'h0;
      last_ff <= '{default: 16'h0};
    end else begin
      cyc_ff <= cyc_ff + 16'h1;
      if (l1_wr_en)
        last_ff[ch] <= l1_wr_data.stamp;
    end
  end
  reset_a: assert property (disable iff (1'b0) !rstn |-> !l1_wr_en && pending == 8'h00)
    else $error("output active in reset");
  pace_a: assert property (l1_wr_en |-> {1'b1, ch} != $past({l1_wr_en, ch})
    && {1'b1, ch} != $past({l1_wr_en, ch}, 2) && {1'b1, ch} != $past({l1_wr_en, ch}, 3))
    else $error("channel written twice within four clocks");
  order_a: assert property (l1_wr_en && $past(l1_wr_en) |-> ch > $past(ch))
    else $error("round not in channel order");
  source_a: assert property (l1_wr_en |-> |($past(pending) & (8'h1 << ch)))
    else $error("write from empty channel");
  pair_a: assert property (l1_wr_en |-> l1_wr_data.paired == cfg.enable_pair)
    else $error("paired flag wrong");
  age_a: assert property (l1_wr_en |-> l1_wr_data.stamp + 16'h4 <= cyc_ff)
    else $error("stamp too recent");
  fifo_a: assert property (l1_wr_en |-> l1_wr_data.stamp >= last_ff[ch])
    else $error("channel order broken");
  for (genvar i = 0; i < 8; i++) begin : g_serve
    serve_a: assert property (pending[i] |-> ##[0:60] l1_wr_en && ch == i)
      else $error("channel waited too long");
  end
endmodule : hit_merge_monitor

bind channel_hit_merge_arbiter hit_merge_monitor u_mon (.sys_clk(sys_clk), .rstn(rstn), .cfg(cfg),
  .hit(hit), .l1_wr_en(l1_wr_en), .l1_wr_data(l1_wr_data), .pending(pending));
`default_nettype wire

// >>> tb/hit_front_end.sv
// Discriminator model: lead pulses, trail pulses a set span later
`timescale 1ns/1ps
`default_nettype none
`include "hit_merge_params.svh"

module hit_front_end (
  // Clock
  input  wire logic        sys_clk,
  // Pulse command
  input  wire logic        go,
  input  wire logic [7:0]  msk,
  input  wire logic [3:0]  wid,
  // Discriminator edges
  output hit_merge_pkg::edge_type [`NUM_CHANNELS-1:0] hit
);
  import hit_merge_pkg::*;
  logic [15:0] hist_ff = 16'h0;
  always_ff @(posedge sys_clk) begin
    hist_ff <= {hist_ff[14:0], go};
  end
  // Edges stay low between pulses; span 0 means no trailing edge
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      hit[i].lead  = msk[i] & hist_ff[0];
      hit[i].trail = msk[i] & (wid != 4'h0) & hist_ff[wid];
    end
  end
endmodule : hit_front_end
`default_nettype wire

// >>> tb/testbench.sv
// Directed bench for the hit merge arbiter
`timescale 1ns/1ps
`default_nettype none
`include "hit_merge_params.svh"

module testbench;
  import hit_merge_pkg::*;
  logic        sys_clk;
  logic        rstn;
  logic        go;
  logic [7:0]  msk;
  logic [3:0]  wid;
  cfg_type     cfg;
  edge_type [`NUM_CHANNELS-1:0] hit;
  logic        l1_wr_en;
  meas_type    l1_wr_data;
  logic [7:0]  pending;
  meas_type    got[$];
  int          n_mismatch = 0;
  int          n_compared = 0;

  hit_front_end u_fe (.sys_clk(sys_clk), .go(go), .msk(msk), .wid(wid), .hit(hit));
  channel_hit_merge_arbiter DUT (.sys_clk(sys_clk), .rstn(rstn), .cfg(cfg), .hit(hit),
    .l1_wr_en(l1_wr_en), .l1_wr_data(l1_wr_data), .pending(pending));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (l1_wr_en === 1'b1)
      got.push_back(l1_wr_data);
  end

  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("Compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic fire(logic [7:0] m, logic [3:0] w, int n);
    @(posedge sys_clk);
    go  <= 1'b1;
    msk <= m;
    wid <= w;
    repeat (n) @(posedge sys_clk);
    go <= 1'b0;
  endtask : fire

  // Idle means no pending channel and no write for 12 clocks
  task automatic drain();
    int quiet = 0;
    for (int k = 0; k < 400 && quiet < 12; k++) begin
      @(posedge sys_clk);
      quiet = (pending == 8'h00 && l1_wr_en == 1'b0) ? quiet + 1 : 0;
    end
    if (quiet < 12) begin
      n_mismatch++;
      $display("[FAIL] drain expected idle seen busy");
      end_sim();
    end
  endtask : drain

  task automatic t_load();
    got.delete();
    fire(8'hff, 4'h0, 2);
    drain();
    chk("words", got.size(), 16);
    foreach (got[k]) chk("channel", got[k].channel, k % 8);
    $display("load test done");
  endtask : t_load

  // Eight back-to-back hits: four fit, at most two pops free room
  task automatic t_over();
    got.delete();
    fire(8'h08, 4'h0, 8);
    drain();
    chk("kept", got.size() inside {[4:6]}, 1);
    $display("overflow test done");
  endtask : t_over

  task automatic t_dead();
    for (int c = 0; c < 4; c++) begin
      cfg.dead_code <= c[1:0];
      got.delete();
      fire(8'h20, 4'h0, 2);
      drain();
      chk("dead", got.size(), c[1:0] == `DEAD_CODE_SHORT ? 1 : 2);
    end
    $display("dead time test done");
  endtask : t_dead

  task automatic t_pair();
    for (int p = 0; p < 2; p++) begin
      cfg.enable_pair <= p[0];
      got.delete();
      fire(8'h02, 4'h5, 1);
      drain();
      chk("words", got.size(), 2 - p);
      chk("paired", got[0].paired, p);
      chk("span", p ? got[0].width : got[1].trailing, p ? 5 : 1);
      if (p == 0)
        chk("gap", got[1].stamp - got[0].stamp, 5);
    end
    $display("pairing test done");
  endtask : t_pair

  task automatic t_pcap();
    got.delete();
    repeat (4) fire(8'h10, 4'h1, 1);
    drain();
    chk("pairs", got.size() inside {[2:3]}, 1);
    $display("pair depth test done");
  endtask : t_pcap

  initial begin
    rstn = 1'b0;
    go   = 1'b0;
    msk  = 8'h00;
    wid  = 4'h0;
    cfg  = '0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    t_load();
    t_over();
    t_dead();
    t_pair();
    t_pcap();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
